// *** rtl/srx_consts.svh ***
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

// Register offsets on the plain register port
`define SRX_A_STAT 3'h0
`define SRX_A_DATA 3'h1
`define SRX_A_CTL1 3'h2
`define SRX_A_CTL2 3'h3
`define SRX_A_BAUD 3'h4

// Reset values and writable masks
`define SRX_STAT_RST 8'hc0
`define SRX_CTL_RST 8'h00
`define SRX_DIV_RST 8'h00
`define SRX_CTL1_MASK 8'h07
`define SRX_CTL2_MASK 8'hfd

// Line status bit positions
`define SRX_TX_HOLDING_EMPTY 7
`define SRX_TC 6
`define SRX_FULL 5
`define SRX_IDLE 4
`define SRX_OVR 3
`define SRX_NF 2
`define SRX_FE 1
`define SRX_PE 0

// Flags cleared by the data read / data write sequences
`define SRX_RXCLR 8'h3f
`define SRX_TXCLR 8'hc1

// Control one bit positions
`define SRX_PCE 2
`define SRX_PS 1
`define SRX_PIE 0

// Control two bit positions
`define SRX_TIE 7
`define SRX_TX_DONE_INT_ENABLE 6
`define SRX_RIE 5
`define SRX_LINE_QUIET_INT_ENABLE 4
`define SRX_TE 3
`define SRX_RE 2
`define SRX_SBK 0

// Sample numbers inside one bit (1 to 16)
`define SRX_S_EDGE 5'h01
`define SRX_S_A 5'h03
`define SRX_S_B 5'h05
`define SRX_S_C 5'h07
`define SRX_S_V0 5'h08
`define SRX_S_V2 5'h0a
`define SRX_S_LAST 5'h10

// Frame geometry in bits and sample ticks
`define SRX_DBITS 4'h8
`define SRX_TX_LAST 4'h9
`define SRX_TX_PH_LAST 4'hf
`define SRX_IDLE_TICKS 8'ha0

`endif

// *** rtl/srx_pkg.sv ***
package srx_pkg;

  // Receiver states, Gray coded along hunt, start, data
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11
  } srx_rx_state_t;

  // Whole state of the serial unit
  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] div;
    logic [7:0] tick_cnt;
    logic [7:0] stat;
    logic nf_pend;
    logic idle_arm;
    logic arm;
    logic bnoise;
    logic [7:0] idle_cnt;
    srx_rx_state_t rxs;
    logic [2:0] hist;
    logic [2:0] smp;
    logic [4:0] ph;
    logic [3:0] bitn;
    logic [7:0] rx_sh;
    logic [7:0] rx_hold;
    logic [7:0] tx_hold;
    logic [9:0] tx_sh;
    logic [3:0] tx_ph;
    logic [3:0] tx_bits;
    logic tx_busy;
    logic tx_brk;
    logic txd;
    logic irq;
    logic wake;
    logic [7:0] rdata;
  } srx_state_t;

endpackage

// *** rtl/srx_serial_unit.sv ***
// Chosen here: strobed register access and the address map.
`include "srx_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Sixteen samples per bit; bit value is majority of samples 8, 9, 10.
// [RULE2] Data bit with samples 8-10 disagreeing sets noise, majority still used.
// [RULE3] Sample phase counter restarts at every detected start edge.
// [RULE4] Start edge noisy unless the three samples before it were all one.
// [RULE5] A one at start samples 3, 5 or 7 spoils the edge, sets noise.
// [RULE6] A one at start samples 8, 9 or 10 sets noise.
// [RULE7] Any enabled interrupt wakes from wait; wait changes nothing else.
// [RULE8] Halt freezes all registers and traffic; nothing here ends halt.
// [RULE9] One interrupt line; each source needs its enable and clear global mask.
// [RULE10] Enables: tx empty, tx done, rx for full and overrun, idle, parity.
// [RULE11] Status is read only, eight flags, resets to 0xc0.
// [RULE12] Tx empty sets on move to shifter; clears by status then data write.
// [RULE13] No move from holding to shifter while tx empty is set.
// [RULE14] Tx done sets at end of data frame; clears by status then data write.
// [RULE15] Tx done stays clear after a break frame.
// [RULE16] Rx full sets on delivery; clears by status then data read.
// [RULE17] Idle sets once, then not again until rx full sets anew.
// [RULE18] Overrun sets on word ready while full; holding kept, shifter overwritten.
// [RULE19] Noise sets with its frame, no own interrupt, clears on status/data read.
// [RULE20] Framing error on bad stop or break, no interrupt; overrun masks it.
// [RULE21] Parity error on parity failure, interrupt if enabled, clears on sequence.
// [RULE22] Rx interrupt enable requests on overrun or rx full.
// [RULE23] Status read arms; next data access completes the clear.
module srx_serial_unit
  import srx_pkg::*;
#(
  parameter logic [7:0] DIV_RST = `SRX_DIV_RST // Sample tick divisor at reset
)
(
  input wire logic clock, // 125 MHz system clock
  input wire logic resetn, // Asynchronous reset
  input wire logic ce, // Clock enable, freezes all when low
  input wire logic halt_mode, // Halt low-power mode
  input wire logic wait_mode, // Wait low-power mode
  input wire logic irq_mask, // Global interrupt mask
  input wire logic [2:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, one cycle after rd
  input wire logic rxd, // Receive line
  output logic txd, // Transmit line
  output logic irq, // Combined interrupt request
  output logic wake_req // Wake request out of wait
);

  srx_state_t st;
  srx_state_t n;
  logic run;
  logic tick;
  logic maj;
  logic deliver;
  logic fe_now;
  logic perr;
  logic irq_src;
  logic stat_rd;
  logic dat_rd;
  logic dat_wr;

  // Majority of three samples, used for start and data bits
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // True while a sample number lies in the voting window
  function automatic logic in_vote(input logic [4:0] p);
    in_vote = (p >= `SRX_S_V0) && (p <= `SRX_S_V2);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign run = ce & ~halt_mode; // [RULE8]
  assign stat_rd = rd && (addr == `SRX_A_STAT);
  assign dat_rd = rd && (addr == `SRX_A_DATA);
  assign dat_wr = wr && (addr == `SRX_A_DATA);

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n = st;
    maj = 1'b0;
    deliver = 1'b0;
    fe_now = 1'b0;
    perr = 1'b0;
    tick = (st.tick_cnt == st.div);
    n.tick_cnt = tick ? 8'h00 : st.tick_cnt + 8'h01;

    // Clear sequence; clears come first so that a same-cycle set wins
    if (stat_rd)
    begin
      n.arm = 1'b1; // [RULE23]
    end
    else if (dat_rd || dat_wr)
    begin
      n.arm = 1'b0;
    end
    if (st.arm && dat_rd)
    begin
      n.stat = n.stat & ~`SRX_RXCLR; // [RULE16] [RULE19] [RULE21] [RULE23]
    end
    if (st.arm && dat_wr)
    begin
      n.stat = n.stat & ~`SRX_TXCLR; // [RULE12] [RULE14] [RULE21]
    end

    // Register writes; status has no write path
    if (wr)
    begin
      case (addr)
        `SRX_A_DATA: n.tx_hold = wdata;
        `SRX_A_CTL1: n.ctl1 = wdata & `SRX_CTL1_MASK;
        `SRX_A_CTL2: n.ctl2 = wdata & `SRX_CTL2_MASK;
        `SRX_A_BAUD: n.div = wdata;
        default: n.div = st.div;
      endcase
    end

    // Read data stands for exactly one cycle
    n.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `SRX_A_STAT: n.rdata = st.stat; // [RULE11]
        `SRX_A_DATA: n.rdata = st.rx_hold;
        `SRX_A_CTL1: n.rdata = st.ctl1;
        `SRX_A_CTL2: n.rdata = st.ctl2;
        `SRX_A_BAUD: n.rdata = st.div;
        default: n.rdata = 8'h00;
      endcase
    end

    // Receiver, one step per sample tick
    if (tick)
    begin
      case (st.rxs)
        RX_HUNT:
        begin
          n.hist = {st.hist[1:0], rxd};
          // Idle needs ten quiet bit times and a fresh frame since the last one
          if (!rxd)
          begin
            n.idle_cnt = 8'h00;
          end
          else if (st.idle_cnt != `SRX_IDLE_TICKS)
          begin
            n.idle_cnt = st.idle_cnt + 8'h01;
          end
          else if (st.idle_arm)
          begin
            n.stat[`SRX_IDLE] = 1'b1;
            n.idle_arm = 1'b0; // [RULE17]
          end
          if (st.ctl2[`SRX_RE] && st.hist[0] && !rxd)
          begin
            n.rxs = RX_START;
            n.ph = `SRX_S_EDGE; // [RULE3]
            n.bnoise = (st.hist != 3'b111); // [RULE4]
          end
        end
        RX_START:
        begin
          n.ph = st.ph + 5'h01;
          if (rxd && (n.ph == `SRX_S_A || n.ph == `SRX_S_B || n.ph == `SRX_S_C))
          begin
            n.bnoise = 1'b1; // [RULE5]
          end
          if (in_vote(n.ph))
          begin
            n.smp = {st.smp[1:0], rxd};
            if (rxd)
            begin
              n.bnoise = 1'b1; // [RULE6]
            end
          end
          // A start bit voted high is dropped; its noise waits for a real frame
          if (n.ph == `SRX_S_V2 && maj3(n.smp))
          begin
            n.nf_pend = 1'b1;
            n.rxs = RX_HUNT;
            n.hist = n.smp;
          end
          if (n.ph == `SRX_S_LAST)
          begin
            n.rxs = RX_DATA;
            n.ph = 5'h00;
            n.bitn = 4'h0;
          end
        end
        RX_DATA:
        begin
          n.ph = st.ph + 5'h01;
          if (in_vote(n.ph))
          begin
            n.smp = {st.smp[1:0], rxd};
          end
          if (n.ph == `SRX_S_V2)
          begin
            maj = maj3(n.smp); // [RULE1]
            if (n.smp != 3'b000 && n.smp != 3'b111)
            begin
              n.bnoise = 1'b1; // [RULE2]
            end
            if (st.bitn != `SRX_DBITS)
            begin
              n.rx_sh = {maj, st.rx_sh[7:1]};
            end
            else
            begin
              // Stop bit decided at its centre so the next edge can be caught
              deliver = 1'b1;
              fe_now = ~maj; // [RULE20]
              n.rxs = RX_HUNT;
              n.hist = {3{maj}};
              n.idle_cnt = 8'h00;
            end
          end
          if (n.ph == `SRX_S_LAST)
          begin
            n.ph = 5'h00;
            n.bitn = st.bitn + 4'h1;
          end
        end
        default: n.rxs = RX_HUNT;
      endcase
    end

    // Hand the word to software, or flag overrun and keep the old word
    if (deliver)
    begin
      perr = st.ctl1[`SRX_PCE] & ((^st.rx_sh) != st.ctl1[`SRX_PS]);
      if (n.stat[`SRX_FULL])
      begin
        n.stat[`SRX_OVR] = 1'b1; // [RULE18] [RULE20]
      end
      else
      begin
        n.rx_hold = st.rx_sh;
        n.stat[`SRX_FULL] = 1'b1; // [RULE16]
        n.stat[`SRX_NF] = n.stat[`SRX_NF] | n.bnoise | st.nf_pend; // [RULE19]
        n.stat[`SRX_FE] = n.stat[`SRX_FE] | fe_now; // [RULE20]
        n.stat[`SRX_PE] = n.stat[`SRX_PE] | perr; // [RULE21]
        n.nf_pend = 1'b0;
        n.idle_arm = 1'b1; // [RULE17]
      end
    end

    // Transmitter; a break takes priority over pending data
    if (!st.tx_busy)
    begin
      if (st.ctl2[`SRX_TE] && st.ctl2[`SRX_SBK])
      begin
        n.tx_sh = 10'h000;
        n.tx_brk = 1'b1;
        n.tx_busy = 1'b1;
        n.tx_ph = 4'h0;
        n.tx_bits = 4'h0;
      end
      else if (st.ctl2[`SRX_TE] && !st.stat[`SRX_TX_HOLDING_EMPTY]) // [RULE13]
      begin
        n.tx_sh = {1'b1, st.tx_hold, 1'b0};
        n.stat[`SRX_TX_HOLDING_EMPTY] = 1'b1; // [RULE12]
        n.tx_brk = 1'b0;
        n.tx_busy = 1'b1;
        n.tx_ph = 4'h0;
        n.tx_bits = 4'h0;
      end
    end
    else if (tick)
    begin
      n.tx_ph = st.tx_ph + 4'h1;
      if (st.tx_ph == `SRX_TX_PH_LAST)
      begin
        n.tx_sh = {1'b1, st.tx_sh[9:1]};
        n.tx_bits = st.tx_bits + 4'h1;
        if (st.tx_bits == `SRX_TX_LAST)
        begin
          n.tx_busy = 1'b0;
          if (!st.tx_brk)
          begin
            n.stat[`SRX_TC] = 1'b1; // [RULE14] [RULE15]
          end
        end
      end
    end
    n.txd = n.tx_busy ? n.tx_sh[0] : 1'b1;

    // Noise and framing share the rx full request, so they feed nothing here
    irq_src = (n.ctl2[`SRX_TIE] & n.stat[`SRX_TX_HOLDING_EMPTY])
            | (n.ctl2[`SRX_TX_DONE_INT_ENABLE] & n.stat[`SRX_TC])
            | (n.ctl2[`SRX_RIE] & (n.stat[`SRX_FULL] | n.stat[`SRX_OVR]))
            | (n.ctl2[`SRX_LINE_QUIET_INT_ENABLE] & n.stat[`SRX_IDLE])
            | (n.ctl1[`SRX_PIE] & n.stat[`SRX_PE]); // [RULE10] [RULE22]
    n.irq = irq_src & ~irq_mask; // [RULE9]
    n.wake = n.irq & wait_mode; // [RULE7]
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; halt and a low enable hold everything
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.stat <= `SRX_STAT_RST; // [RULE11]
      st.div <= DIV_RST;
      st.hist <= 3'b111;
      st.txd <= 1'b1;
    end
    else if (run) // [RULE8]
    begin
      st <= n;
    end
  end

  // Outputs straight from the state flops
  assign rdata = st.rdata;
  assign txd = st.txd;
  assign irq = st.irq;
  assign wake_req = st.wake;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_status_read: assert property ( // [RULE11]
    run && stat_rd |=> st.rdata == $past(st.stat))
    else $error("status read data wrong");

  a_read_one_cycle: assert property ( // [RULE11]
    run && !rd |=> st.rdata == 8'h00)
    else $error("read data stands too long");

  a_start_realign: assert property ( // [RULE3]
    st.rxs == RX_START && $past(st.rxs) == RX_HUNT |-> st.ph == `SRX_S_EDGE)
    else $error("phase not realigned at start edge");

  a_overrun_keeps: assert property ( // [RULE18]
    $rose(st.stat[`SRX_OVR]) |-> $stable(st.rx_hold) && st.stat[`SRX_FULL])
    else $error("overrun lost holding word");

  a_fe_masked: assert property ( // [RULE20]
    $rose(st.stat[`SRX_OVR]) |-> !$rose(st.stat[`SRX_FE]))
    else $error("framing set with overrun");

  // A clear and a delivery in one cycle leave full high, so no rise is required
  a_nf_with_full: assert property ( // [RULE19]
    $rose(st.stat[`SRX_NF]) |-> st.stat[`SRX_FULL] && $past(deliver))
    else $error("noise set without a delivered frame");

  a_idle_armed: assert property ( // [RULE17]
    $rose(st.stat[`SRX_IDLE]) |-> $past(st.idle_arm))
    else $error("idle set twice without new frame");

  a_tx_load_empty: assert property ( // [RULE13]
    $rose(st.tx_busy) && !st.tx_brk |-> !$past(st.stat[`SRX_TX_HOLDING_EMPTY]) && st.stat[`SRX_TX_HOLDING_EMPTY])
    else $error("transmit load with empty flag set");

  a_tc_no_break: assert property ( // [RULE15]
    $rose(st.stat[`SRX_TC]) |-> !st.tx_brk && !st.tx_busy)
    else $error("done flag after break");

  a_mask_blocks: assert property ( // [RULE9]
    run && irq_mask |=> !st.irq)
    else $error("interrupt despite global mask");

  // Only an edge that updated the state may be held against the old wait input
  a_wake_irq: assert property ( // [RULE7]
    $past(run) && st.wake |-> st.irq && $past(wait_mode))
    else $error("wake without interrupt");

  a_sequence_needed: assert property ( // [RULE23]
    run && dat_rd && !st.arm && st.stat[`SRX_FULL] |=> st.stat[`SRX_FULL])
    else $error("full cleared without status read");

endmodule

// *** dv/srx_far_tx.sv ***
////////////////////////////////////////
// Remote transmitter model driving the receive line
module srx_far_tx
(
  input wire logic clock, // Bench clock, one sample tick per cycle
  output logic line // Receive line, idles high
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line rests high, as the pull-up would hold it
  initial line = 1'b1;

  // Start, eight bits LSB first, stop; sixteen ticks a bit
  // A glitch inverts sample gs of frame bit gb to probe the vote window
  task automatic send(input logic [7:0] d, input logic stop, input int gb, input int gs);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int b = 0; b < 10; b++)
    begin
      for (int s = 1; s <= 16; s++)
      begin
        line <= (b == gb && s == gs) ? ~f[b] : f[b];
        @(posedge clock);
      end
    end
  endtask

  // Holds a level, used to shorten the idle run before a start edge
  task automatic drive(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clock);
  endtask
endmodule

// *** dv/serial_rx_sampling_status_bench.sv ***
`include "srx_consts.svh"

////////////////////////////////////////
// Register-level bench with a remote transmitter on the line
module serial_rx_sampling_status_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic halt_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic irq_mask = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic irq;
  logic wake_req;
  logic [7:0] v;
  int fail_count = 0;
  int n_tests = 0;
  // Vote cases: frame bit, glitched sample, noise expected (bit i)
  int gb[12] = '{1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0};
  int gs[12] = '{0, 8, 9, 10, 7, 11, 3, 5, 7, 9, 4, 6};
  logic [11:0] nf = 12'b0011_1100_1110;
  logic [7:0] en[3] = '{8'h80, 8'h40, 8'h00};

  // Divisor zero keeps bits at sixteen cycles for a short run
  srx_serial_unit #(.DIV_RST(8'h00)) dut_u
  (
    .clock(clock), .resetn(resetn), .ce(ce), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .irq_mask(irq_mask), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq),
    .wake_req(wake_req)
  );
  srx_far_tx far_u (.clock(clock), .line(rxd));

  // 125 MHz clock
  initial forever #4 clock = ~clock;

  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobe drops after its edge, so back-to-back calls never reassign it
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask

  // Status then data read; idle bit masked since its timing is free-running
  task automatic take(input logic [7:0] st, input logic [7:0] d);
    rd_reg(`SRX_A_STAT, v);
    check("status", v & 8'hef, st);
    rd_reg(`SRX_A_DATA, v);
    check("data", v, d);
  endtask

  // Samples the transmit line mid-bit, starting one cycle after the write
  task automatic tx_bits(input logic [9:0] f);
    repeat (8) @(posedge clock);
    for (int b = 0; b < 10; b++)
    begin
      #1 check("txd", {7'h00, txd}, {7'h00, f[b]});
      repeat (16) @(posedge clock);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd_reg(`SRX_A_STAT, v);
    check("status", v, 8'hc0);
    wr_reg(`SRX_A_STAT, 8'h00);
    rd_reg(`SRX_A_STAT, v);
    check("status", v, 8'hc0);
    rd_reg(3'h5, v);
    check("unmapped", v, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(`SRX_A_CTL2, en[i]);
      #1 check("irq", {7'h00, irq}, (i < 2) ? 8'h01 : 8'h00);
    end
    $display("test reset and enables done");
    wr_reg(`SRX_A_CTL2, 8'h24);
    for (int i = 0; i < 12; i++)
    begin
      far_u.send(8'h3c, 1'b1, gb[i], gs[i]);
      if (i == 0)
      begin
        #1 check("irq", {7'h00, irq}, 8'h01);
        irq_mask <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check("irq", {7'h00, irq}, 8'h00);
        irq_mask <= 1'b0;
        wait_mode <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check("wake", {7'h00, wake_req}, 8'h01);
        wait_mode <= 1'b0;
        halt_mode <= 1'b1;
        rd_reg(`SRX_A_STAT, v);
        check("halted read", v, 8'h00);
        halt_mode <= 1'b0;
      end
      take({5'h1c, nf[i], 2'h0}, 8'h3c);
    end
    $display("test sampling done");
    // Second word lands on a full holder with a bad stop: overrun only
    far_u.send(8'h11, 1'b1, 0, 0);
    far_u.send(8'h22, 1'b0, 0, 0);
    take(8'he8, 8'h11);
    // Short idle run before the edge: two ones spoil it, three do not
    for (int p = 2; p < 4; p++)
    begin
      far_u.drive(1'b1, 20);
      far_u.send(8'h33, 1'b0, 0, 0);
      take(8'he2, 8'h33);
      far_u.drive(1'b1, p);
      far_u.send(8'h3c, 1'b1, 0, 0);
      take((p == 2) ? 8'he4 : 8'he0, 8'h3c);
    end
    // A start voted high is dropped; its noise shows with the next frame
    far_u.drive(1'b0, 8);
    far_u.drive(1'b1, 20);
    far_u.send(8'h5a, 1'b1, 0, 0);
    take(8'he4, 8'h5a);
    $display("test errors done");
    wr_reg(`SRX_A_CTL2, 8'h04);
    for (int ps = 0; ps < 2; ps++)
    begin
      wr_reg(`SRX_A_CTL1, {5'h00, 1'b1, ps[0], 1'b1});
      far_u.send(8'h01, 1'b1, 0, 0);
      #1 check("irq", {7'h00, irq}, (ps == 0) ? 8'h01 : 8'h00);
      take((ps == 0) ? 8'he1 : 8'he0, 8'h01);
    end
    wr_reg(`SRX_A_CTL1, 8'h00);
    $display("test parity done");
    wr_reg(`SRX_A_CTL2, 8'h0c);
    rd_reg(`SRX_A_STAT, v);
    wr_reg(`SRX_A_DATA, 8'h96);
    tx_bits({1'b1, 8'h96, 1'b0});
    rd_reg(`SRX_A_STAT, v);
    check("status", v & 8'hef, 8'hc0);
    // Write without the status access: tx empty stays set, nothing leaves
    rd_reg(`SRX_A_DATA, v);
    wr_reg(`SRX_A_DATA, 8'h0f);
    tx_bits(10'h3ff);
    rd_reg(`SRX_A_STAT, v);
    wr_reg(`SRX_A_DATA, 8'h5a);
    rd_reg(`SRX_A_STAT, v);
    check("status", v & 8'hef, 8'h80);
    repeat (170) @(posedge clock);
    // Break first, data queued behind it: no done flag when the break ends
    wr_reg(`SRX_A_CTL2, 8'h0d);
    rd_reg(`SRX_A_STAT, v);
    wr_reg(`SRX_A_DATA, 8'h00);
    wr_reg(`SRX_A_CTL2, 8'h0c);
    #1 check("break", {7'h00, txd}, 8'h00);
    repeat (160) @(posedge clock);
    rd_reg(`SRX_A_STAT, v);
    check("status", v & 8'hef, 8'h80);
    repeat (170) @(posedge clock);
    $display("test transmit done");
    wr_reg(`SRX_A_CTL2, 8'h14);
    take(8'hc0, 8'h01);
    repeat (200) @(posedge clock);
    rd_reg(`SRX_A_STAT, v);
    check("idle", v & 8'h10, 8'h00);
    far_u.send(8'h44, 1'b1, 0, 0);
    repeat (200) @(posedge clock);
    rd_reg(`SRX_A_STAT, v);
    check("status", v, 8'hf0);
    #1 check("irq", {7'h00, irq}, 8'h01);
    $display("test idle done");
    end_of_test();
  end

  // Watchdog well beyond the expected run of about five thousand cycles
  initial
  begin
    repeat (40000) @(posedge clock);
    $display("watchdog expired");
    fail_count++;
    end_of_test();
  end
endmodule
